// file: design/jmb_fifo.sv
`timescale 1ns/100ps
module jmb_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wr_r] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            if (pop)
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: design/jmb_port_ctrl.sv
`timescale 1ns/100ps
module jmb_port_ctrl
    import jmb_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       tck_b,
    input  wire logic       tms_b,
    input  wire logic       tdi_b,
    input  wire logic       trst_n,
    input  wire logic [2:0] lp_tdi,
    output logic            tdo_b,
    output logic            tdo_b_oe,
    output logic      [2:0] lp_tck,
    output logic      [2:0] lp_tms,
    output logic      [2:0] lp_tdo,
    output logic            sig_fifo_ready
);
    // ------------------------------------------------------------------
    // Pin synchronisation and clock edges
    // ------------------------------------------------------------------
    logic [6:0] sync_w;
    logic       tck_s;
    logic       tms_s;
    logic       tdi_s;
    logic [2:0] lp_tdi_s;
    logic       trst_n_s;
    logic       tck_d_r;
    logic       rise;
    logic       fall;

    jmb_sync #(.WIDTH(7)) u_sync (
        .clk  (core_clk),
        .din  ({trst_n, lp_tdi, tdi_b, tms_b, tck_b}),
        .dout (sync_w)
    );

    assign {trst_n_s, lp_tdi_s, tdi_s, tms_s, tck_s} = sync_w;

    always_ff @(posedge core_clk)
    begin
        if (srst)
            tck_d_r <= 1'b0;
        else
            tck_d_r <= tck_s;
    end

    assign rise = tck_s & ~tck_d_r;
    assign fall = ~tck_s & tck_d_r;

    // ------------------------------------------------------------------
    // Bridge TAP controller
    // ------------------------------------------------------------------
    jmb_tap_type tap_r;
    jmb_tap_type tap_nxt;
    logic        level1;
    logic        shift_dr;
    logic        dr_phase;

    always_comb
    begin
        case (tap_r)
            TAP_TLR:  tap_nxt = tms_s ? TAP_TLR  : TAP_RTI;
            TAP_RTI:  tap_nxt = tms_s ? TAP_SDR  : TAP_RTI;
            TAP_SDR:  tap_nxt = tms_s ? TAP_SIR  : TAP_CDR;
            TAP_CDR:  tap_nxt = tms_s ? TAP_E1DR : TAP_SHDR;
            TAP_SHDR: tap_nxt = tms_s ? TAP_E1DR : TAP_SHDR;
            TAP_E1DR: tap_nxt = tms_s ? TAP_UDR  : TAP_PDR;
            TAP_PDR:  tap_nxt = tms_s ? TAP_E2DR : TAP_PDR;
            TAP_E2DR: tap_nxt = tms_s ? TAP_UDR  : TAP_SHDR;
            TAP_UDR:  tap_nxt = tms_s ? TAP_SDR  : TAP_RTI;
            TAP_SIR:  tap_nxt = tms_s ? TAP_TLR  : TAP_CIR;
            TAP_CIR:  tap_nxt = tms_s ? TAP_E1IR : TAP_SHIR;
            TAP_SHIR: tap_nxt = tms_s ? TAP_E1IR : TAP_SHIR;
            TAP_E1IR: tap_nxt = tms_s ? TAP_UIR  : TAP_PIR;
            TAP_PIR:  tap_nxt = tms_s ? TAP_E2IR : TAP_PIR;
            TAP_E2IR: tap_nxt = tms_s ? TAP_UIR  : TAP_SHIR;
            TAP_UIR:  tap_nxt = tms_s ? TAP_SDR  : TAP_RTI;
            default:  tap_nxt = TAP_TLR;
        endcase
    end

    // Synchronised test reset pin forces the reset state without waiting for a TCK rise
    always_ff @(posedge core_clk)
    begin
        if (srst || !trst_n_s)
            tap_r <= TAP_TLR;
        else if (rise)
            tap_r <= tap_nxt;
    end

    assign level1   = (tap_r == TAP_TLR) | srst;
    assign shift_dr = (tap_r == TAP_SHDR);
    assign dr_phase = (tap_r inside {TAP_CDR, TAP_SHDR, TAP_E1DR,
                                     TAP_PDR, TAP_E2DR, TAP_UDR});

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    logic [7:0] ir_sh_r;
    logic [7:0] ir_r;

    always_ff @(posedge core_clk)
    begin
        if (level1)
        begin
            ir_sh_r <= IR_RESET;
            ir_r    <= IR_RESET;
        end
        else if (rise)
        begin
            case (tap_r)
                TAP_CIR:  ir_sh_r <= IR_CAPTURE;
                TAP_SHIR: ir_sh_r <= {tdi_s, ir_sh_r[7:1]};
                TAP_UIR:  ir_r    <= ir_sh_r;
                default:  ir_r    <= ir_r;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Data registers
    // ------------------------------------------------------------------
    logic [6:0]  cfg_r;
    logic [7:0]  cfg_sh_r;
    logic [1:0]  grp_r;
    logic [1:0]  grp_sh_r;
    logic [31:0] id_sh_r;
    logic        byp_r;
    logic [31:0] cnt_r;
    logic [15:0] sig_r;
    logic        cnt_en_r;
    logic        cnt_flag;
    logic        cnt_shift;

    assign cnt_flag  = cnt_en_r & (cnt_r == COUNT_RESET);
    assign cnt_shift = shift_dr & (ir_r == IR_COUNTER_SELECT);

    always_ff @(posedge core_clk)
    begin
        if (level1)
        begin
            cfg_r    <= CFG_RESET;
            cfg_sh_r <= {1'b0, CFG_RESET};
            grp_r    <= GROUP_RESET;
            grp_sh_r <= GROUP_RESET;
            id_sh_r  <= ID_VALUE;
            byp_r    <= 1'b0;
        end
        else if (rise)
        begin
            if (tap_r == TAP_CDR)
            begin
                cfg_sh_r <= {cnt_flag, cfg_r};
                grp_sh_r <= grp_r;
                id_sh_r  <= ID_VALUE;
                byp_r    <= 1'b0;
            end
            else if (shift_dr)
            begin
                case (ir_r)
                    IR_CONFIG_SELECT: cfg_sh_r <= {tdi_s, cfg_sh_r[7:1]};
                    IR_GROUP_SELECT:  grp_sh_r <= {tdi_s, grp_sh_r[1]};
                    IR_IDENT:         id_sh_r  <= {tdi_s, id_sh_r[31:1]};
                    default:          byp_r    <= tdi_s;
                endcase
            end
            else if (tap_r == TAP_UDR)
            begin
                // Bit 7 read-only, bits 5-6 reserved
                if (ir_r == IR_CONFIG_SELECT)
                    cfg_r <= cfg_sh_r[6:0] & CFG_WR_MASK;
                if (ir_r == IR_GROUP_SELECT)
                    grp_r <= grp_sh_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock down-counter
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (level1)
        begin
            cnt_r    <= COUNT_RESET;
            cnt_en_r <= 1'b0;
        end
        else if (rise)
        begin
            if (tap_r == TAP_UIR && ir_sh_r == IR_COUNTER_ON)
                cnt_en_r <= 1'b1;
            else if (tap_r == TAP_UIR && ir_sh_r == IR_COUNTER_OFF)
                cnt_en_r <= 1'b0;
            if (cnt_shift)
                cnt_r <= {tdi_s, cnt_r[31:1]};
            else if (cnt_en_r && cnt_r != COUNT_RESET &&
                     !(dr_phase && ir_r == IR_COUNTER_SELECT))
                cnt_r <= cnt_r - 32'h00000001;
        end
    end

    // ------------------------------------------------------------------
    // Local port controllers and serial path
    // ------------------------------------------------------------------
    jmb_lp_type lp_r [NUM_PORTS];
    logic [3:0] chain;
    logic [2:0] pad_r;
    logic [2:0] active;
    logic       reg_out;
    logic       resume;
    logic       park_run;

    assign resume = (ir_r == IR_RESUME);
    // Counter overrides the stop bit while enabled
    assign park_run = cnt_en_r ? (cnt_r != COUNT_RESET)
                               : ~cfg_r[CFG_CLK_STOP];

    always_comb
    begin
        if (tap_r == TAP_SHIR)
            reg_out = ir_sh_r[0];
        else
            case (ir_r)
                IR_CONFIG_SELECT:  reg_out = cfg_sh_r[0];
                IR_GROUP_SELECT:   reg_out = grp_sh_r[0];
                IR_IDENT:          reg_out = id_sh_r[0];
                IR_SIG_SELECT:     reg_out = sig_r[0];
                IR_COUNTER_SELECT: reg_out = cnt_r[0];
                default:           reg_out = byp_r;
            endcase
    end

    assign chain[0] = reg_out;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++)
        begin : g_port
            logic sel;

            // Loopback stops every parked port from resuming into the path
            assign sel = cfg_r[gi] & ~cfg_r[CFG_LOOPBACK];
            assign active[gi] = (lp_r[gi] == LP_ACTIVE);
            // Parked ports are skipped entirely
            assign chain[gi+1] = active[gi] ? pad_r[gi] : chain[gi];

            always_ff @(posedge core_clk)
            begin
                if (level1)
                    lp_r[gi] <= LP_PARK_TLR;
                else if (ir_r == IR_LOCAL_RESET)
                    lp_r[gi] <= LP_PARK_TLR;
                else if (fall && lp_r[gi] == LP_PARK_TLR && resume && sel)
                    lp_r[gi] <= LP_WAIT_RTI;
                else if (rise)
                begin
                    case (lp_r[gi])
                        LP_WAIT_RTI, LP_PARK_RTI:
                            if (resume && sel && tap_r == TAP_RTI)
                                lp_r[gi] <= LP_ACTIVE;
                        LP_PARK_PDR:
                            if (resume && sel && tap_r == TAP_PDR)
                                lp_r[gi] <= LP_ACTIVE;
                        LP_PARK_PIR:
                            if (resume && sel && tap_r == TAP_PIR)
                                lp_r[gi] <= LP_ACTIVE;
                        LP_ACTIVE:
                            if (ir_r == IR_PARK_RESET)
                                lp_r[gi] <= LP_PARK_TLR;
                            else if (ir_r == IR_PARK_IDLE &&
                                     tap_r == TAP_RTI)
                                lp_r[gi] <= LP_PARK_RTI;
                            else if (ir_r == IR_PARK_PAUSE &&
                                     tap_r == TAP_PDR)
                                lp_r[gi] <= LP_PARK_PDR;
                            else if (ir_r == IR_PARK_PAUSE &&
                                     tap_r == TAP_PIR)
                                lp_r[gi] <= LP_PARK_PIR;
                        default:
                            lp_r[gi] <= lp_r[gi];
                    endcase
                end
            end

            always_ff @(posedge core_clk)
            begin
                if (srst)
                begin
                    lp_tms[gi] <= 1'b1;
                    lp_tck[gi] <= 1'b0;
                    lp_tdo[gi] <= 1'b0;
                    pad_r[gi]  <= 1'b0;
                end
                else
                begin
                    // High parks in reset, low holds idle or pause
                    lp_tms[gi] <= active[gi] ? tms_s
                                : (lp_r[gi] == LP_PARK_TLR);
                    lp_tck[gi] <= tck_s & (active[gi] | park_run);
                    if (fall)
                        lp_tdo[gi] <= chain[gi];
                    if (rise)
                        pad_r[gi] <= lp_tdi_s[gi];
                end
            end
        end
    endgenerate

    // Backplane data output changes on the falling clock edge
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            tdo_b    <= 1'b0;
            tdo_b_oe <= 1'b0;
        end
        else if (fall)
        begin
            tdo_b    <= chain[NUM_PORTS];
            tdo_b_oe <= shift_dr | (tap_r == TAP_SHIR);
        end
    end

    // ------------------------------------------------------------------
    // Signature compactor
    // ------------------------------------------------------------------
    // Bits queue here so a compactor scan can hold off compaction
    logic        sig_en_r;
    logic        sig_shift;
    logic        q_valid;
    logic        q_data;
    logic        q_ready;
    logic        q_push;
    logic        fb;

    assign sig_shift = shift_dr & (ir_r == IR_SIG_SELECT);
    assign q_ready   = ~sig_shift;
    assign q_push    = rise & shift_dr & sig_en_r & (active != 3'b000);
    assign fb        = sig_r[15] ^ q_data;

    jmb_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (core_clk),
        .srst      (srst),
        .in_valid  (q_push),
        .in_ready  (sig_fifo_ready),
        .in_data   (chain[NUM_PORTS]),
        .out_valid (q_valid),
        .out_ready (q_ready),
        .out_data  (q_data)
    );

    always_ff @(posedge core_clk)
    begin
        if (level1)
        begin
            sig_r    <= SIG_RESET;
            sig_en_r <= 1'b0;
        end
        else
        begin
            if (rise && tap_r == TAP_UIR && ir_sh_r == IR_SIG_ON)
                sig_en_r <= 1'b1;
            else if (rise && tap_r == TAP_UIR && ir_sh_r == IR_SIG_OFF)
                sig_en_r <= 1'b0;
            if (rise && sig_shift)
                sig_r <= {tdi_s, sig_r[15:1]};
            else if (q_valid && q_ready)
                sig_r <= {sig_r[14:0], 1'b0} ^ (fb ? SIG_POLY : 16'h0000);
        end
    end
endmodule

// file: design/jmb_sync.sv
`timescale 1ns/100ps
module jmb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    // Two stages; only the second stage is read outside
    always_ff @(posedge clk)
    begin
        meta_r <= din;
        dout   <= meta_r;
    end
endmodule

// file: include/jmb_pkg.sv
package jmb_pkg;

    // ------------------------------------------------------------------
    // Bridge TAP controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        TAP_TLR  = 4'b0000, TAP_RTI  = 4'b0001, TAP_SDR  = 4'b0010,
        TAP_CDR  = 4'b0011, TAP_SHDR = 4'b0100, TAP_E1DR = 4'b0101,
        TAP_PDR  = 4'b0110, TAP_E2DR = 4'b0111, TAP_UDR  = 4'b1000,
        TAP_SIR  = 4'b1001, TAP_CIR  = 4'b1010, TAP_SHIR = 4'b1011,
        TAP_E1IR = 4'b1100, TAP_PIR  = 4'b1101, TAP_E2IR = 4'b1110,
        TAP_UIR  = 4'b1111
    } jmb_tap_type;

    // ------------------------------------------------------------------
    // Local port controller states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LP_PARK_TLR = 3'b000, LP_WAIT_RTI = 3'b001, LP_PARK_RTI = 3'b010,
        LP_PARK_PDR = 3'b011, LP_PARK_PIR = 3'b100, LP_ACTIVE   = 3'b101
    } jmb_lp_type;

    // ------------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------------
    localparam logic [7:0] IR_IDENT          = 8'haa;
    localparam logic [7:0] IR_BYPASS         = 8'hff;
    localparam logic [7:0] IR_CONFIG_SELECT  = 8'h8e;
    localparam logic [7:0] IR_GROUP_SELECT   = 8'h03;
    localparam logic [7:0] IR_RESUME         = 8'he7;
    localparam logic [7:0] IR_PARK_IDLE      = 8'h84;
    localparam logic [7:0] IR_PARK_RESET     = 8'hc6;
    localparam logic [7:0] IR_PARK_PAUSE     = 8'h85;
    localparam logic [7:0] IR_LOCAL_RESET    = 8'h88;
    localparam logic [7:0] IR_SIG_SELECT     = 8'h82;
    localparam logic [7:0] IR_SIG_ON         = 8'h0c;
    localparam logic [7:0] IR_SIG_OFF        = 8'h8d;
    localparam logic [7:0] IR_COUNTER_SELECT = 8'h0e;
    localparam logic [7:0] IR_COUNTER_ON     = 8'h0f;
    localparam logic [7:0] IR_COUNTER_OFF    = 8'h90;
    localparam logic [7:0] IR_CAPTURE        = 8'h01;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  IR_RESET      = 8'haa;
    localparam logic [6:0]  CFG_RESET     = 7'h01;
    localparam logic [6:0]  CFG_WR_MASK   = 7'h1f;
    localparam logic [1:0]  GROUP_RESET   = 2'h0;
    localparam logic [15:0] SIG_RESET     = 16'h0000;
    localparam logic [31:0] COUNT_RESET   = 32'h00000000;
    localparam logic [15:0] SIG_POLY      = 16'h100b;
    localparam int          CFG_CLK_STOP  = 3;
    localparam int          CFG_LOOPBACK  = 4;
    localparam int          NUM_PORTS     = 3;
    localparam int          FIFO_DEPTH    = 4;

    // Identification fields: values are arbitrary
    localparam logic [3:0]  ID_VERSION = 4'h1;
    localparam logic [15:0] ID_PART    = 16'h1234;
    localparam logic [10:0] ID_MAKER   = 11'h055;
    localparam logic [31:0] ID_VALUE   = {ID_VERSION, ID_PART, ID_MAKER,
                                          1'b1};

endpackage

// file: tb/jmb_local_chain.sv
`timescale 1ns/100ps
module jmb_local_chain (
    input  wire logic [2:0] lp_tck,
    input  wire logic [2:0] lp_tdo,
    output logic      [2:0] lp_tdi
);
    // One-bit chain per port; output moves on the falling local clock
    for (genvar i = 0; i < 3; i++)
    begin : g_port
        logic q;
        always_ff @(posedge lp_tck[i])
            q <= lp_tdo[i];
        always_ff @(negedge lp_tck[i])
            lp_tdi[i] <= q;
    end
endmodule

// file: tb/jmb_port_ctrl_props.sv
`timescale 1ns/100ps
module jmb_port_ctrl_chk (
    input wire logic       core_clk,
    input wire logic       srst,
    input wire logic       tck_b,
    input wire logic       tms_b,
    input wire logic       tdi_b,
    input wire logic       trst_n,
    input wire logic [2:0] lp_tdi,
    input wire logic       tdo_b,
    input wire logic       tdo_b_oe,
    input wire logic [2:0] lp_tck,
    input wire logic [2:0] lp_tms,
    input wire logic [2:0] lp_tdo,
    input wire logic       sig_fifo_ready
);
    logic [1:0] tq;
    logic [3:0] fall_age;
    logic [2:0] hi_cnt;
    // ------------------------------------------------------------------
    // Backplane clock edge tracking
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        tq <= {tq[0], tck_b};
        if (srst)
        begin
            fall_age <= 4'hf;
            hi_cnt   <= 3'd0;
        end
        else
        begin
            if (tq == 2'b10)
                fall_age <= 4'h0;
            else if (fall_age != 4'hf)
                fall_age <= fall_age + 4'h1;
            if (tq == 2'b01)
                hi_cnt <= tms_b ? hi_cnt + {2'd0, hi_cnt != 3'd7} : 3'd0;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst || !trst_n);
    sequence five_high;
        $rose(hi_cnt == 3'd5);
    endsequence
    reset_vals_a: assert property (disable iff (1'b0) srst |=>
        lp_tms == 3'b111 && lp_tck == 3'b000 && !tdo_b_oe && !tdo_b)
        else $error("outputs not at reset values");
    fifo_ready_a: assert property (disable iff (1'b0) srst |=>
        sig_fifo_ready) else $error("compactor queue not empty");
    trst_park_a: assert property (disable iff (srst)
        (!trst_n)[*6] |-> lp_tms == 3'b111)
        else $error("test reset did not park ports");
    tms_reset_a: assert property (five_high |->
        ##[1:6] lp_tms == 3'b111) else $error("five high tms no park");
    tdo_fall_a: assert property ($changed(tdo_b) |->
        fall_age <= 4'd4) else $error("tdo_b moved off falling edge");
    oe_fall_a: assert property ($changed(tdo_b_oe) |->
        fall_age <= 4'd4) else $error("tdo_b_oe moved off falling edge");
    lp_tdo_fall_a: assert property ($changed(lp_tdo) |->
        fall_age <= 4'd4) else $error("lp_tdo moved off falling edge");
    lp_tck_low_a: assert property ((!tck_b)[*4] |->
        lp_tck == 3'b000) else $error("local clock high while tck low");
endmodule

bind jmb_port_ctrl jmb_port_ctrl_chk i_chk (.core_clk(core_clk),
    .srst(srst), .tck_b(tck_b), .tms_b(tms_b), .tdi_b(tdi_b),
    .trst_n(trst_n), .lp_tdi(lp_tdi), .tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe),
    .lp_tck(lp_tck), .lp_tms(lp_tms), .lp_tdo(lp_tdo),
    .sig_fifo_ready(sig_fifo_ready));

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench
    import jmb_pkg::*;
;
    logic        core_clk;
    logic        srst;
    logic        tck_b;
    logic        tms_b;
    logic        tdi_b;
    logic        trst_n;
    logic [2:0]  lp_tdi;
    logic        tdo_b;
    logic        tdo_b_oe;
    logic [2:0]  lp_tck;
    logic [2:0]  lp_tms;
    logic [2:0]  lp_tdo;
    logic        sig_fifo_ready;
    logic        seen_clr;
    logic        full_seen;
    logic [15:0] e;
    logic [2:0]  seen;
    logic [31:0] d;
    logic        t;
    int          miscompares;
    int          comparisons;
    jmb_port_ctrl i_dut (.core_clk(core_clk), .srst(srst), .tck_b(tck_b),
        .tms_b(tms_b), .tdi_b(tdi_b), .trst_n(trst_n), .lp_tdi(lp_tdi),
        .tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe), .lp_tck(lp_tck),
        .lp_tms(lp_tms), .lp_tdo(lp_tdo), .sig_fifo_ready(sig_fifo_ready));
    jmb_local_chain i_far (.lp_tck(lp_tck), .lp_tdo(lp_tdo), .lp_tdi(lp_tdi));
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Clear wins over a clock pulse still in flight
    always @(posedge core_clk)
    begin
        seen      <= seen_clr ? 3'b000 : (seen | lp_tck);
        full_seen <= seen_clr ? 1'b0 : (full_seen | ~sig_fifo_ready);
    end
    // ------------------------------------------------------------------
    // Backplane access tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One backplane clock: 4 core cycles low, tdo taken at the rise
    task automatic clk1(input logic ms, input logic di, output logic dout);
        @(negedge core_clk);
        tck_b = 1'b0;
        tms_b = ms;
        tdi_b = di;
        repeat (4) @(negedge core_clk);
        dout = tdo_b;
        tck_b = 1'b1;
        repeat (3) @(negedge core_clk);
    endtask
    task automatic idle(input int n);
        logic x;
        repeat (n) clk1(1'b0, 1'b0, x);
    endtask
    // From Run-Test/Idle, scan n bits LSB first, back to Run-Test/Idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic x;
        dout = '0;
        clk1(1'b1, 1'b0, x);
        if (ir)
            clk1(1'b1, 1'b0, x);
        clk1(1'b0, 1'b0, x);
        clk1(1'b0, 1'b0, x);
        for (int i = 0; i < n; i++)
        begin
            clk1(i == n - 1, din[i], x);
            dout[i] = x;
        end
        clk1(1'b1, 1'b0, x);
        clk1(1'b0, 1'b0, x);
    endtask
    task automatic clr_seen();
        seen_clr = 1'b1;
        @(negedge core_clk);
        seen_clr = 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge core_clk);
        miscompares++;
        give_verdict();
    end
    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial
    begin
        miscompares = 0;
        comparisons = 0;
        srst = 1'b1;
        tck_b = 1'b0;
        tms_b = 1'b1;
        tdi_b = 1'b0;
        trst_n = 1'b1;
        seen_clr = 1'b0;
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        repeat (4) @(negedge core_clk);
        repeat (5) clk1(1'b1, 1'b0, t);
        idle(1);
        scan(1'b0, 32, 32'h0, d);
        chk("ident", ID_VALUE, d);
        $display("test ident done");
        scan(1'b1, 8, IR_CONFIG_SELECT, d);
        chk("ir_capture", 32'h01, d);
        scan(1'b0, 8, 32'h08, d);
        chk("config_reset", 32'h01, d);
        clr_seen();
        idle(2);
        chk("clock_stop", 32'h0, seen);
        scan(1'b0, 8, 32'h00, d);
        chk("config_write", 32'h08, d);
        clr_seen();
        idle(2);
        chk("clock_run", 32'h7, seen);
        $display("test config done");
        scan(1'b1, 8, IR_COUNTER_ON, d);
        scan(1'b1, 8, IR_COUNTER_SELECT, d);
        scan(1'b0, 32, 32'd6, d);
        chk("count_reset", 32'h0, d);
        scan(1'b1, 8, IR_CONFIG_SELECT, d);
        scan(1'b0, 8, 32'h00, d);
        chk("count_status", 32'h80, d);
        clr_seen();
        idle(2);
        chk("count_stop", 32'h0, seen);
        scan(1'b1, 8, IR_COUNTER_OFF, d);
        clr_seen();
        idle(2);
        chk("count_off", 32'h7, seen);
        $display("test counter done");
        scan(1'b1, 8, IR_CONFIG_SELECT, d);
        scan(1'b0, 8, 32'h01, d);
        scan(1'b1, 8, IR_RESUME, d);
        idle(1);
        chk("unpark_tms", 32'h6, lp_tms);
        scan(1'b0, 8, 32'h15, d);
        chk("port_path", 32'h15, d >> 3);
        scan(1'b1, 8, IR_LOCAL_RESET, d);
        idle(1);
        chk("local_reset", 32'h7, lp_tms);
        $display("test ports done");
        trst_n = 1'b0;
        repeat (8) @(negedge core_clk);
        chk("trst_park", 32'h7, lp_tms);
        trst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        idle(1);
        scan(1'b0, 32, 32'h0, d);
        chk("ir_reset", ID_VALUE, d);
        $display("test reset done");
        scan(1'b1, 8, IR_RESUME, d);
        idle(1);
        scan(1'b1, 8, IR_SIG_ON, d);
        scan(1'b0, 8, 32'h15, d);
        chk("sig_path", 32'h15, d >> 3);
        // Compactor sees exactly the bits that leave on the data output
        e = SIG_RESET;
        for (int k = 0; k < 8; k++)
            e = {e[14:0], 1'b0} ^ ((e[15] ^ d[k]) ? SIG_POLY : 16'h0000);
        chk("fifo_drain", 32'h0, full_seen);
        scan(1'b1, 8, IR_SIG_SELECT, d);
        scan(1'b0, 18, 32'h0, d);
        chk("signature", e, d[17:2]);
        chk("fifo_full", 32'h1, full_seen);
        $display("test compactor done");
        give_verdict();
    end
endmodule
